/* rtl/iel_top.sv */
`timescale 1ns/1ps
module iel_top (
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [iel_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Interrupt sources
    input  wire logic                       pin_irq0_n,
    input  wire logic                       pin_irq1_n,
    input  wire logic                       timer0_overflow,
    input  wire logic                       timer1_overflow,
    input  wire logic                       timer2_overflow,
    input  wire logic                       timer2_capture,
    input  wire logic                       uart_rx_flag,
    input  wire logic                       uart_tx_flag,
    input  wire logic                       shift_done,
    // CPU core side
    output logic                            cpu_irq_req,
    output logic      [2:0]                 cpu_irq_vec,
    // Event interrupt
    output logic                            irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]                       en_r;
    logic [iel_pkg::NUM_SRC-1:0]      mask_r;
    logic [iel_pkg::NUM_SRC-1:0]      status_q;
    logic [iel_pkg::NUM_SRC-1:0]      status_set;
    logic [iel_pkg::NUM_SRC-1:0]      status_clr;
    logic [iel_pkg::NUM_FLG-1:0]      flags_q;
    logic [iel_pkg::NUM_FLG-1:0]      flags_set;
    logic [iel_pkg::NUM_FLG-1:0]      flags_clr;
    logic                             shift_done_q;
    logic                             shift_irq_en_r;
    logic                             shift_armed_r;
    logic                             shift_clr;
    logic [3:0]                       slot_r;
    logic                             t0_pend_r;
    logic                             t1_pend_r;
    logic                             t2_pend_r;
    logic                             pready_r;
    logic [31:0]                      prdata_r;
    logic                             pslverr_r;
    iel_pkg::iel_cpu_t                cpu_r;
    logic                             irq_r;
    logic                             wr_fire;
    logic                             rd_fire;
    logic                             poll;
    iel_pkg::iel_req_t                raw_w;
    iel_pkg::iel_req_t                req_w;
    logic [2:0]                       first_w;
    logic [31:0]                      rdata_nxt;
    logic                             rerr_nxt;

    assign wr_fire = psel & penable & pready_r & pwrite;
    assign rd_fire = psel & penable & pready_r & ~pwrite;
    assign poll    = (slot_r == iel_pkg::SLOT_POLL);

    // ------------------------------------------------------------------
    // Machine cycle slot counter
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_r <= 4'h0;
        end else if (slot_r == iel_pkg::SLOT_LAST) begin
            slot_r <= 4'h0;
        end else begin
            slot_r <= slot_r + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Timer flags
    // ------------------------------------------------------------------
    // An overflow pulse is held until its flag slot comes round.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0_pend_r <= 1'b0;
            t1_pend_r <= 1'b0;
            t2_pend_r <= 1'b0;
        end else begin
            t0_pend_r <= timer0_overflow | (t0_pend_r & (slot_r != iel_pkg::SLOT_STATE5_PH2));
            t1_pend_r <= timer1_overflow | (t1_pend_r & (slot_r != iel_pkg::SLOT_STATE5_PH2));
            t2_pend_r <= timer2_overflow | (t2_pend_r & (slot_r != iel_pkg::SLOT_STATE2_PH2));
        end
    end

    always_comb begin
        flags_set = '0;
        flags_set[iel_pkg::FLG_T0_OVF] = t0_pend_r & (slot_r == iel_pkg::SLOT_STATE5_PH2);
        flags_set[iel_pkg::FLG_T1_OVF] = t1_pend_r & (slot_r == iel_pkg::SLOT_STATE5_PH2);
        flags_set[iel_pkg::FLG_T2_OVF] = t2_pend_r & (slot_r == iel_pkg::SLOT_STATE2_PH2);
        flags_set[iel_pkg::FLG_T2_CAP] = timer2_capture;
    end

    assign flags_clr = (wr_fire && paddr == iel_pkg::OFF_FLAGS) ?
                       pwdata[iel_pkg::NUM_FLG-1:0] : '0;

    iel_sticky #(.W(iel_pkg::NUM_FLG)) u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (flags_set),
        .clr     (flags_clr),
        .q       (flags_q)
    );

    // ------------------------------------------------------------------
    // Shift port completion flag
    // ------------------------------------------------------------------
    // status read arms, data access clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_armed_r <= 1'b0;
        end else if (!shift_done_q || shift_clr) begin
            shift_armed_r <= 1'b0;
        end else if (rd_fire && paddr == iel_pkg::OFF_SHIFT_STAT) begin
            shift_armed_r <= 1'b1;
        end
    end

    assign shift_clr = shift_armed_r & psel & penable & pready_r &
                       (paddr == iel_pkg::OFF_SHIFT_DATA);

    iel_sticky #(.W(1)) u_shift (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (shift_done),
        .clr     (shift_clr),
        .q       (shift_done_q)
    );

    // ------------------------------------------------------------------
    // Enable, mask and shift control registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= iel_pkg::EN_RESET;
        end else if (wr_fire && paddr == iel_pkg::OFF_ENABLE) begin
            en_r <= pwdata[7:0] & iel_pkg::EN_IMPL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= iel_pkg::MASK_RESET;
        end else if (wr_fire && paddr == iel_pkg::OFF_MASK) begin
            mask_r <= pwdata[iel_pkg::NUM_SRC-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_irq_en_r <= 1'b0;
        end else if (wr_fire && paddr == iel_pkg::OFF_SHIFT_CTRL) begin
            shift_irq_en_r <= pwdata[0];
        end
    end

    // ------------------------------------------------------------------
    // Request forming and selection
    // ------------------------------------------------------------------
    always_comb begin
        raw_w.pin0   = ~pin_irq0_n;
        raw_w.timer0 = flags_q[iel_pkg::FLG_T0_OVF];
        raw_w.pin1   = ~pin_irq1_n;
        raw_w.timer1 = flags_q[iel_pkg::FLG_T1_OVF];
        raw_w.serial = uart_rx_flag | uart_tx_flag | (shift_done_q & shift_irq_en_r);
        raw_w.timer2 = flags_q[iel_pkg::FLG_T2_OVF] | flags_q[iel_pkg::FLG_T2_CAP];
    end

    assign req_w = en_r[iel_pkg::EN_GLOBAL_BIT] ? (raw_w & en_r[iel_pkg::NUM_SRC-1:0]) : '0;

    always_comb begin
        first_w = iel_pkg::VEC_PIN0;
        for (int i = iel_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req_w[i]) begin
                first_w = 3'(i);
            end
        end
    end

    // sampled at the poll slot only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_r <= '0;
        end else if (poll) begin
            cpu_r.req <= |req_w;
            cpu_r.vec <= first_w;
        end
    end

    assign cpu_irq_req = cpu_r.req;
    assign cpu_irq_vec = cpu_r.vec;

    // ------------------------------------------------------------------
    // Event status and interrupt output
    // ------------------------------------------------------------------
    assign status_set = poll ? req_w : '0;
    assign status_clr = (wr_fire && paddr == iel_pkg::OFF_STATUS) ?
                        pwdata[iel_pkg::NUM_SRC-1:0] : '0;

    iel_sticky #(.W(iel_pkg::NUM_SRC)) u_status (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (status_set),
        .clr     (status_clr),
        .q       (status_q)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_q & mask_r);
        end
    end

    assign irq = irq_r;

    // ------------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        rerr_nxt  = 1'b0;
        case (paddr)
            iel_pkg::OFF_STATUS:     rdata_nxt[iel_pkg::NUM_SRC-1:0] = status_q;
            iel_pkg::OFF_MASK:       rdata_nxt[iel_pkg::NUM_SRC-1:0] = mask_r;
            iel_pkg::OFF_FLAGS:      rdata_nxt[iel_pkg::NUM_FLG-1:0] = flags_q;
            iel_pkg::OFF_SHIFT_CTRL: rdata_nxt[0] = shift_irq_en_r;
            iel_pkg::OFF_SHIFT_STAT: rdata_nxt[0] = shift_done_q;
            iel_pkg::OFF_SHIFT_DATA: rdata_nxt = 32'h0000_0000;
            iel_pkg::OFF_ENABLE:     rdata_nxt[7:0] = en_r;
            default:                 rerr_nxt = 1'b1;
        endcase
    end

    // The answer is prepared in the setup cycle and given one access cycle later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel & ~penable;
            prdata_r  <= (psel & ~penable & ~pwrite) ? rdata_nxt : 32'h0000_0000;
            pslverr_r <= psel & ~penable & rerr_nxt;
        end
    end

    assign pready  = pready_r;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_status_read_armed;
        rd_fire && paddr == iel_pkg::OFF_SHIFT_STAT && shift_done_q;
    endsequence

    sequence s_data_touch;
        psel && penable && pready_r && paddr == iel_pkg::OFF_SHIFT_DATA;
    endsequence

    a_shift_two_step: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(shift_done_q) |-> $past(shift_armed_r) && $past(shift_clr))
        else $error("Shift flag cleared without status read then data access.");

    a_shift_clear_seq: assert property (@(posedge pclk) disable iff (!presetn)
        s_status_read_armed
        ##1 (!(psel && penable && pready_r && paddr == iel_pkg::OFF_SHIFT_DATA))[*2]
        ##1 (s_data_touch and !shift_done)
        |=> !shift_done_q)
        else $error("Shift flag not cleared by data access after status read.");

    a_global_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (poll && !en_r[iel_pkg::EN_GLOBAL_BIT]) |=> !cpu_irq_req)
        else $error("Request given while global enable is off.");

    a_poll_moment: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(cpu_irq_req) |-> $past(slot_r) == iel_pkg::SLOT_POLL)
        else $error("Request changed outside the poll slot.");

    a_t0_flag_slot: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flags_q[iel_pkg::FLG_T0_OVF]) |-> $past(slot_r) == iel_pkg::SLOT_STATE5_PH2)
        else $error("Timer 0 flag set outside state5 phase2.");

    a_t2_flag_slot: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flags_q[iel_pkg::FLG_T2_OVF]) |-> $past(slot_r) == iel_pkg::SLOT_STATE2_PH2)
        else $error("Timer 2 flag set outside state2 phase2.");

    a_t2_same_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(flags_q[iel_pkg::FLG_T2_OVF]) && en_r[7] && en_r[5] && !wr_fire)
        |-> ##[1:7] cpu_irq_req)
        else $error("Timer 2 request not polled within its machine cycle.");

    a_t2_flag_held: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_q[iel_pkg::FLG_T2_OVF] && !flags_clr[iel_pkg::FLG_T2_OVF])
        |=> flags_q[iel_pkg::FLG_T2_OVF])
        else $error("Timer 2 flag cleared without software.");

    a_pin0_first: assert property (@(posedge pclk) disable iff (!presetn)
        (poll && req_w.pin0) |=> cpu_irq_vec == iel_pkg::VEC_PIN0 && cpu_irq_req)
        else $error("Pin 0 request not selected first.");

    a_shift_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (poll && !shift_irq_en_r && !uart_rx_flag && !uart_tx_flag)
        |=> !(cpu_irq_req && cpu_irq_vec == iel_pkg::VEC_SERIAL))
        else $error("Serial request without a serial source.");

    a_rsvd_bit_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !en_r[iel_pkg::EN_RSVD_BIT])
        else $error("Reserved enable bit holds a one.");

    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("Bus answer not one cycle after setup.");

endmodule // iel_top

/* rtl/iel_pkg.sv */
package iel_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFF_STATUS      = 8'h00;
    localparam logic [7:0]  OFF_MASK        = 8'h04;
    localparam logic [7:0]  OFF_FLAGS       = 8'h08;
    localparam logic [7:0]  OFF_SHIFT_CTRL  = 8'h0C;
    localparam logic [7:0]  OFF_SHIFT_STAT  = 8'h10;
    localparam logic [7:0]  OFF_SHIFT_DATA  = 8'h14;
    localparam logic [7:0]  OFF_ENABLE      = 8'hA8;

    // ------------------------------------------------------------------
    // Enable register fields and reset values
    // ------------------------------------------------------------------
    localparam int          EN_GLOBAL_BIT   = 7;
    localparam int          EN_RSVD_BIT     = 6;
    localparam int          NUM_SRC         = 6;
    localparam logic [7:0]  EN_RESET        = 8'h00;
    localparam logic [7:0]  EN_IMPL_MASK    = 8'hBF;
    localparam logic [5:0]  STATUS_RESET    = 6'h00;
    localparam logic [5:0]  MASK_RESET      = 6'h00;

    // Source flag register fields.
    localparam int          FLG_T0_OVF      = 0;
    localparam int          FLG_T1_OVF      = 1;
    localparam int          FLG_T2_OVF      = 2;
    localparam int          FLG_T2_CAP      = 3;
    localparam int          NUM_FLG         = 4;
    localparam logic [3:0]  FLAGS_RESET     = 4'h0;

    // ------------------------------------------------------------------
    // Machine cycle timing: six states of two phases, one clock each
    // ------------------------------------------------------------------
    localparam int          MCYC_CLKS       = 12;
    localparam logic [3:0]  SLOT_LAST       = 4'(MCYC_CLKS - 1);
    localparam logic [3:0]  SLOT_STATE2_PH2 = 4'h3;
    localparam logic [3:0]  SLOT_STATE5_PH2 = 4'h9;
    localparam logic [3:0]  SLOT_POLL       = 4'h9;

    // Vector numbers, in the order of the fixed selection.
    localparam logic [2:0]  VEC_PIN0        = 3'h0;
    localparam logic [2:0]  VEC_TIMER0      = 3'h1;
    localparam logic [2:0]  VEC_PIN1        = 3'h2;
    localparam logic [2:0]  VEC_TIMER1      = 3'h3;
    localparam logic [2:0]  VEC_SERIAL      = 3'h4;
    localparam logic [2:0]  VEC_TIMER2      = 3'h5;

    // Requests in enable register bit order.
    typedef struct packed {
        logic timer2;
        logic serial;
        logic timer1;
        logic pin1;
        logic timer0;
        logic pin0;
    } iel_req_t;

    typedef struct packed {
        logic        req;
        logic [2:0]  vec;
    } iel_cpu_t;

endpackage

/* rtl/iel_sticky.sv */
`timescale 1ns/1ps
module iel_sticky #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Set and clear
    input  wire logic [W-1:0]  set,
    input  wire logic [W-1:0]  clr,
    // Held bits
    output logic      [W-1:0]  q
);

    // A set in the same cycle as a clear wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= (q & ~clr) | set;
        end
    end

endmodule // iel_sticky

/* tb/iel_cpu_model.sv */
`timescale 1ns/1ps
module iel_cpu_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Request from the block
    input  wire logic       cpu_irq_req,
    input  wire logic [2:0] cpu_irq_vec,
    // Vector taken by the core
    output logic            taken_r,
    output logic      [2:0] taken_vec_r
);
    // ------------------------------------------------------------------
    // Poll latch of the core
    // ------------------------------------------------------------------
    // The core has no acknowledge path, so vectoring leaves every flag set.
    // six vectors, no clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_r     <= 1'b0;
            taken_vec_r <= 3'h7;
        end else begin
            taken_r     <= cpu_irq_req && (cpu_irq_vec <= 3'h5);
            taken_vec_r <= cpu_irq_req ? cpu_irq_vec : 3'h7;
        end
    end
endmodule // iel_cpu_model

/* tb/test_interrupt_enable_and_request_logic.sv */
`timescale 1ns/1ps
module test_interrupt_enable_and_request_logic;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        pin0_n  = 1'b1;
    logic        pin1_n  = 1'b1;
    logic        urx     = 1'b0;
    logic        utx     = 1'b0;
    logic [4:0]  pulse   = 5'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cpu_irq_req;
    logic [2:0]  cpu_irq_vec;
    logic        irq;
    logic        taken;
    logic [2:0]  taken_vec;
    logic [32:0] exp_q[$];
    logic [7:0]  r;
    int          n_fail          = 0;
    int          samples_checked = 0;
    int          cycles          = 0;

    always #5 pclk = ~pclk;

    iel_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_irq0_n(pin0_n), .pin_irq1_n(pin1_n),
        .timer0_overflow(pulse[0]), .timer1_overflow(pulse[1]),
        .timer2_overflow(pulse[2]), .timer2_capture(pulse[3]),
        .uart_rx_flag(urx), .uart_tx_flag(utx), .shift_done(pulse[4]),
        .cpu_irq_req(cpu_irq_req), .cpu_irq_vec(cpu_irq_vec), .irq(irq));

    iel_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .cpu_irq_req(cpu_irq_req),
        .cpu_irq_vec(cpu_irq_vec), .taken_r(taken), .taken_vec_r(taken_vec));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Read answers are compared against the oldest note in the queue.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                check({pslverr, prdata}, 33'h1_FFFF_FFFF);
            end else begin
                check({pslverr, prdata}, exp_q.pop_front());
            end
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic tp(input logic [4:0] v);
        @(posedge pclk);
        pulse <= v;
        @(posedge pclk);
        pulse <= 5'h00;
    endtask

    // Waits past two polls, then looks at what the core latched.
    task automatic expect_req(input logic req, input logic [2:0] v);
        repeat (30) @(posedge pclk);
        #1;
        check({29'h0, taken, taken_vec}, {29'h0, req, req ? v : 3'h7});
    endtask

    task automatic irq_is(input logic v);
        repeat (3) @(posedge pclk);
        #1;
        check({32'h0, irq}, {32'h0, v});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(91));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(iel_pkg::OFF_ENABLE, {25'h0, iel_pkg::EN_RESET});
        rd(8'h40, 33'h1_0000_0000);
        for (int i = 0; i < 4; i++) begin
            r = ((i == 0) ? 8'hFF : 8'($urandom)) & iel_pkg::EN_IMPL_MASK;
            wr(iel_pkg::OFF_ENABLE, {24'h0, r});
            rd(iel_pkg::OFF_ENABLE, {25'h0, r});
        end
        // All six sources pending at once.
        @(posedge pclk);
        pin0_n <= 1'b0;
        pin1_n <= 1'b0;
        urx    <= 1'b1;
        tp(5'h07);
        for (int k = 0; k < 6; k++) begin
            wr(iel_pkg::OFF_ENABLE, {24'h0, 8'h80 | ((8'h3F << k) & 8'h3F)});
            expect_req(1'b1, 3'(k));
            wr(iel_pkg::OFF_ENABLE, {24'h0, 8'h80 | (8'h01 << k)});
            expect_req(1'b1, 3'(k));
        end
        wr(iel_pkg::OFF_ENABLE, 32'h3F);
        expect_req(1'b0, 3'h0);
        rd(iel_pkg::OFF_FLAGS, 33'h7);
        // Timer 2 capture alone.
        @(posedge pclk);
        pin0_n <= 1'b1;
        pin1_n <= 1'b1;
        urx    <= 1'b0;
        wr(iel_pkg::OFF_FLAGS, 32'hF);
        wr(iel_pkg::OFF_ENABLE, 32'hA0);
        tp(5'h08);
        expect_req(1'b1, iel_pkg::VEC_TIMER2);
        rd(iel_pkg::OFF_FLAGS, 33'h8);
        wr(iel_pkg::OFF_FLAGS, 32'h8);
        expect_req(1'b0, 3'h0);
        // Serial sources and the shift completion gate.
        wr(iel_pkg::OFF_ENABLE, 32'h90);
        @(posedge pclk);
        utx <= 1'b1;
        expect_req(1'b1, iel_pkg::VEC_SERIAL);
        @(posedge pclk);
        utx <= 1'b0;
        tp(5'h10);
        expect_req(1'b0, 3'h0);
        wr(iel_pkg::OFF_SHIFT_CTRL, 32'h1);
        expect_req(1'b1, iel_pkg::VEC_SERIAL);
        wr(iel_pkg::OFF_ENABLE, 32'h80);
        expect_req(1'b0, 3'h0);
        rd(iel_pkg::OFF_SHIFT_STAT, 33'h1);
        rd(iel_pkg::OFF_SHIFT_DATA, 33'h0);
        rd(iel_pkg::OFF_SHIFT_STAT, 33'h0);
        // Sticky status, mask and the level interrupt.
        wr(iel_pkg::OFF_STATUS, 32'h3F);
        rd(iel_pkg::OFF_STATUS, 33'h0);
        irq_is(1'b0);
        wr(iel_pkg::OFF_MASK, 32'h02);
        wr(iel_pkg::OFF_ENABLE, 32'h82);
        tp(5'h01);
        expect_req(1'b1, iel_pkg::VEC_TIMER0);
        irq_is(1'b1);
        rd(iel_pkg::OFF_STATUS, 33'h2);
        wr(iel_pkg::OFF_MASK, 32'h0);
        irq_is(1'b0);
        wr(iel_pkg::OFF_FLAGS, 32'h1);
        expect_req(1'b0, 3'h0);
        wr(iel_pkg::OFF_STATUS, 32'h02);
        wr(iel_pkg::OFF_MASK, 32'h02);
        irq_is(1'b0);
        print_verdict();
    end
endmodule // test_interrupt_enable_and_request_logic
